// ### hw/mrl_pkg.sv
// Purpose: constants and carrier types for the monitor result and limit register slice
// Assumes: 16-bit registers reached by an 8-bit register pointer, one clock, synchronous reset
// Notes: results and limits share one signed layout, sign in bit 15, value in bits 15..3
package mrl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register pointer values
    localparam logic [7:0] ADDR_CH2_BUS_RESULT = 8'h04;
    localparam logic [7:0] ADDR_CH3_SHUNT_RESULT = 8'h05;
    localparam logic [7:0] ADDR_CH3_BUS_RESULT = 8'h06;
    localparam logic [7:0] ADDR_CH1_FAST_LIMIT = 8'h07;
    localparam logic [7:0] ADDR_CH1_SUSTAINED_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_CH2_FAST_LIMIT = 8'h09;
    localparam logic [7:0] ADDR_CH2_SUSTAINED_LIMIT = 8'h0a;

    ////////////////////////////////////////////////////////////////////////////////
    // field layout and reset values
    localparam int SIGN_BIT = 15;
    localparam int MAG_MSB = 14;
    localparam int MAG_LSB = 3;
    localparam int DATA_BITS = 13;
    localparam int ACC_BITS = 24;
    localparam logic [15:0] DATA_MASK = 16'hfff8;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    localparam logic [15:0] LIMIT_RESET = 16'h7ff8;
    localparam logic [15:0] FULL_SCALE_CODE = 16'h7ff8;
    // weight of the lowest data bit, in microvolts
    localparam int SHUNT_STEP_UV = 40;
    localparam int BUS_STEP_UV = 8000;

    ////////////////////////////////////////////////////////////////////////////////
    // slot and limit indices
    localparam int NUM_CH = 3;
    localparam int NUM_SLOTS = 6;
    localparam int NUM_LIMITS = 4;
    localparam int KIND_SHUNT = 0;
    localparam int KIND_BUS = 1;
    localparam int LIM_FAST = 0;
    localparam int LIM_SUSTAINED = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // conversion mode field: bit 0 shunt, bit 1 bus, bit 2 continuous
    localparam int MODE_SHUNT_BIT = 0;
    localparam int MODE_BUS_BIT = 1;
    localparam int MODE_CONT_BIT = 2;
    localparam logic [2:0] MODE_DEFAULT = 3'h7;
    localparam logic [2:0] AVG_DEFAULT = 3'h0;

    typedef struct packed {
        logic valid;
        logic [1:0] ch;
        logic is_bus;
        logic [15:0] data;
    } mrl_conv_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } mrl_reg_req_t;

    // log2 of the sample count: 1,4,16,64,128,256,512,1024
    function automatic logic [3:0] avg_shift(input logic [2:0] sel);
        case (sel)
            3'h0: avg_shift = 4'h0;
            3'h1: avg_shift = 4'h2;
            3'h2: avg_shift = 4'h4;
            3'h3: avg_shift = 4'h6;
            3'h4: avg_shift = 4'h7;
            3'h5: avg_shift = 4'h8;
            3'h6: avg_shift = 4'h9;
            default: avg_shift = 4'ha;
        endcase
    endfunction

endpackage

// ### hw/mrl_regs.sv
// Purpose: result and limit registers of a three-channel shunt and bus monitor, with averaging and alerts
// Assumes: conversion results arrive as single-cycle strobes from logic on the same clock
// Notes: register access is a pointer-style port driven by the serial interface engine
`timescale 1ns/10ps

module mrl_regs (
    input wire logic clk,
    input wire logic rst,
    input mrl_pkg::mrl_conv_t conv,
    input wire logic [2:0] sample_count_select,
    input wire logic [2:0] conversion_mode_select,
    input mrl_pkg::mrl_reg_req_t req,
    output logic [15:0] rdata,
    output logic [1:0] fast_alert,
    output logic [1:0] sustained_alert,
    output logic [1:0] avg_done
);

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [mrl_pkg::NUM_SLOTS-1:0][mrl_pkg::ACC_BITS-1:0] acc;
        logic [mrl_pkg::NUM_SLOTS-1:0][10:0] cnt;
        logic [mrl_pkg::NUM_SLOTS-1:0][15:0] result;
        logic [mrl_pkg::NUM_LIMITS-1:0][15:0] limit;
        logic [1:0] fast_alert;
        logic [1:0] sustained_alert;
        logic [1:0] avg_done;
        logic [15:0] rdata;
    } mrl_state_t;

    mrl_state_t state;
    mrl_state_t next_state;

    // limit register index for a write or read pointer, or all ones when not a limit
    function automatic logic [2:0] limit_index(input logic [7:0] addr);
        case (addr)
            mrl_pkg::ADDR_CH1_FAST_LIMIT: limit_index = 3'h0;
            mrl_pkg::ADDR_CH1_SUSTAINED_LIMIT: limit_index = 3'h1;
            mrl_pkg::ADDR_CH2_FAST_LIMIT: limit_index = 3'h2;
            mrl_pkg::ADDR_CH2_SUSTAINED_LIMIT: limit_index = 3'h3;
            default: limit_index = 3'h7;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [2:0] slot;
        logic [3:0] shift;
        logic [10:0] count_target;
        logic signed [mrl_pkg::ACC_BITS-1:0] sample;
        logic signed [mrl_pkg::ACC_BITS-1:0] sum;
        logic signed [mrl_pkg::ACC_BITS-1:0] avg;
        logic [15:0] masked;
        logic [15:0] avg_word;
        logic accept;
        logic [2:0] widx;
        logic [2:0] ridx;
        slot = {conv.ch, conv.is_bus};
        shift = mrl_pkg::avg_shift(sample_count_select);
        count_target = 11'h1 << shift;
        masked = conv.data & mrl_pkg::DATA_MASK;
        // 13-bit signed field sign-extended into the accumulator
        sample = {{(mrl_pkg::ACC_BITS-mrl_pkg::DATA_BITS){masked[mrl_pkg::SIGN_BIT]}},
                  masked[mrl_pkg::SIGN_BIT:mrl_pkg::MAG_LSB]};
        sum = $signed(state.acc[slot]) + sample;
        avg = sum >>> shift;
        avg_word = {avg[mrl_pkg::DATA_BITS-1:0], 3'h0};
        widx = limit_index(req.addr);
        ridx = limit_index(req.addr);
        // power-down and single-kind modes drop the unwanted conversions
        accept = conv.valid && (conv.ch < 2'(mrl_pkg::NUM_CH)) &&
                 (conv.is_bus ? conversion_mode_select[mrl_pkg::MODE_BUS_BIT]
                              : conversion_mode_select[mrl_pkg::MODE_SHUNT_BIT]);

        next_state = state;
        next_state.avg_done = 2'h0;

        if (accept) begin
            // codes are kept as raw scaled words: 40 uV or 8 mV per step of bit 3
            if (state.cnt[slot] + 11'h1 >= count_target) begin
                next_state.result[slot] = avg_word;
                next_state.acc[slot] = '0;
                next_state.cnt[slot] = 11'h0;
            end else begin
                next_state.acc[slot] = sum;
                next_state.cnt[slot] = state.cnt[slot] + 11'h1;
            end
        end

        // channel 1 and 2 shunt alerts
        if (accept && !conv.is_bus && conv.ch < 2'h2) begin
            // fast path watches each raw conversion so short spikes are not averaged away
            next_state.fast_alert[conv.ch[0]] =
                $signed(masked) > $signed(state.limit[{conv.ch[0], 1'b0}]);
            if (state.cnt[slot] + 11'h1 >= count_target) begin
                next_state.sustained_alert[conv.ch[0]] =
                    $signed(avg_word) > $signed(state.limit[{conv.ch[0], 1'b1}]);
                next_state.avg_done[conv.ch[0]] = 1'b1;
            end
        end

        // reserved low bits of the limits are held at zero so a compare sees only the field
        if (req.wr && widx != 3'h7) begin
            next_state.limit[widx[1:0]] = req.wdata & mrl_pkg::DATA_MASK;
        end

        if (req.rd) begin
            case (req.addr)
                mrl_pkg::ADDR_CH2_BUS_RESULT: next_state.rdata = state.result[3];
                mrl_pkg::ADDR_CH3_SHUNT_RESULT: next_state.rdata = state.result[4];
                mrl_pkg::ADDR_CH3_BUS_RESULT: next_state.rdata = state.result[5];
                default: next_state.rdata = (ridx != 3'h7) ? state.limit[ridx[1:0]] : 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (rst) begin
            state.acc <= '0;
            state.cnt <= '0;
            state.result <= {mrl_pkg::NUM_SLOTS{mrl_pkg::RESULT_RESET}};
            state.limit <= {mrl_pkg::NUM_LIMITS{mrl_pkg::LIMIT_RESET}};
            state.fast_alert <= 2'h0;
            state.sustained_alert <= 2'h0;
            state.avg_done <= 2'h0;
            state.rdata <= 16'h0000;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
    assign fast_alert = state.fast_alert;
    assign sustained_alert = state.sustained_alert;
    assign avg_done = state.avg_done;

endmodule // mrl_regs

// ### sim/mrl_host.sv
// Purpose: register host issuing pointer reads and writes
// Assumes: one request at a time
// Notes: an idle cycle separates requests
`timescale 1ns/10ps
module mrl_host (
    input wire logic clk,
    input wire logic [15:0] rdata,
    output mrl_pkg::mrl_reg_req_t req
);
    initial req = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        @(posedge clk);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0};
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        v = rdata;
    endtask
endmodule // mrl_host

// ### sim/mrl_regs_monitor.sv
// Purpose: port checks for the result and limit slice
// Assumes: one clock, sync active-high reset
// Notes: bound to every mrl_regs
`timescale 1ns/10ps
module mrl_regs_monitor (
    input wire logic clk,
    input wire logic rst,
    input mrl_pkg::mrl_conv_t conv,
    input wire logic [2:0] sample_count_select,
    input wire logic [2:0] conversion_mode_select,
    input mrl_pkg::mrl_reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic [1:0] fast_alert,
    input wire logic [1:0] sustained_alert,
    input wire logic [1:0] avg_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire logic ch1_take = conv.valid && conv.ch == 2'h0 && !conv.is_bus && conversion_mode_select[0];
    sequence lim_wr; req.wr && !req.rd && req.addr inside {[8'h07:8'h0a]}; endsequence
    sequence same_rd; req.rd && !req.wr && $stable(req.addr); endsequence
    a_reset_clears: assert property (disable iff (1'b0) rst |=> rdata == 16'h0 && avg_done == 2'h0)
        else $error("reset left state");
    a_low_zero: assert property (rdata[2:0] == 3'h0) else $error("low bits set");
    a_rdata_holds: assert property (!req.rd |=> $stable(rdata)) else $error("rdata moved");
    a_unmapped_zero: assert property (req.rd && !(req.addr inside {[8'h04:8'h0a]}) |=> rdata == 16'h0)
        else $error("unmapped read");
    // the host leaves one idle cycle between a write and the read that follows it
    a_limit_back: assert property (lim_wr ##2 same_rd |=> rdata == ($past(req.wdata, 3) & 16'hfff8))
        else $error("limit readback");
    a_power_down: assert property (conv.valid && conversion_mode_select[1:0] == 2'h0 |=> avg_done == 2'h0)
        else $error("power-down accepted");
    a_fast_cause: assert property ($changed(fast_alert[0]) |-> $past(ch1_take)) else $error("fast alert");
    a_sust_cause: assert property ($changed(sustained_alert[1]) |-> avg_done[1]) else $error("sust alert");
    a_single_done: assert property (sample_count_select == 3'h0 && ch1_take |=> avg_done[0])
        else $error("no done");
endmodule // mrl_regs_monitor
bind mrl_regs mrl_regs_monitor mrl_regs_monitor_inst (.clk, .rst, .conv, .sample_count_select,
    .conversion_mode_select, .req, .rdata, .fast_alert, .sustained_alert, .avg_done);

// ### sim/mrl_regs_test.sv
// Purpose: register and alert tests
// Assumes: mrl_host drives the register port
// Notes: limits are written before alert tests
`timescale 1ns/10ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; $display("BAD %0t %h %h", $time, g, e); end end
module mrl_regs_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mrl_pkg::mrl_conv_t conv = '0;
    logic [2:0] avg_sel = 3'h0;
    logic [2:0] mode_sel = 3'h7;
    mrl_pkg::mrl_reg_req_t req;
    logic [15:0] rdata;
    logic [15:0] d;
    logic [1:0] fast_alert;
    logic [1:0] sustained_alert;
    logic [1:0] avg_done;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    mrl_regs mrl_regs_inst (.clk(clk), .rst(rst), .conv(conv), .sample_count_select(avg_sel),
        .conversion_mode_select(mode_sel), .req(req), .rdata(rdata), .fast_alert(fast_alert),
        .sustained_alert(sustained_alert), .avg_done(avg_done));
    mrl_host mrl_host_inst (.clk(clk), .rdata(rdata), .req(req));
    task automatic send(input logic [1:0] ch, input logic bus, input logic [15:0] v);
        @(posedge clk);
        conv <= '{valid: 1'b1, ch: ch, is_bus: bus, data: v};
        @(posedge clk);
        conv.valid <= 1'b0;
        #1;
    endtask
    task automatic expect_reg(input logic [7:0] a, input logic [15:0] e);
        mrl_host_inst.rd(a, d);
        `CHK(d, e)
    endtask
    task automatic complete_run();
        $display("runs %0d bad %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard: whole run is well under 1000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int a = 4; a < 11; a++) expect_reg(8'(a), a < 7 ? 16'h0 : 16'h7ff8);
        expect_reg(8'h0b, 16'h0);
        for (int a = 7; a < 11; a++) begin
            mrl_host_inst.wr(8'(a), 16'h8007 + 16'(a));
            expect_reg(8'(a), (16'h8007 + 16'(a)) & 16'hfff8);
        end
        mrl_host_inst.wr(8'h05, 16'h1238);
        expect_reg(8'h05, 16'h0);
        $display("registers done");
        avg_sel <= 3'h1;
        repeat (3) send(2'h2, 1'b0, 16'h0100);
        expect_reg(8'h05, 16'h0);
        send(2'h2, 1'b0, 16'h0100);
        expect_reg(8'h05, 16'h0100);
        repeat (3) send(2'h2, 1'b1, 16'hfffd);
        send(2'h2, 1'b1, 16'h0000);
        expect_reg(8'h06, 16'hfff8);
        avg_sel <= 3'h0;
        send(2'h1, 1'b1, 16'h7fff);
        expect_reg(8'h04, 16'h7ff8);
        $display("averaging done");
        mrl_host_inst.wr(8'h07, 16'h0100);
        send(2'h0, 1'b0, 16'h0108);
        `CHK({fast_alert[0], sustained_alert[0], avg_done}, 4'hd)
        send(2'h0, 1'b0, 16'h0100);
        `CHK(fast_alert[0], 1'b0)
        send(2'h1, 1'b0, 16'h8008);
        `CHK({fast_alert[1], sustained_alert[1]}, 2'h0)
        send(2'h1, 1'b0, 16'h0008);
        `CHK({fast_alert[1], sustained_alert[1], avg_done}, 4'he)
        // sustained limits raised apart from the fast ones, so a swapped limit index shows
        mrl_host_inst.wr(8'h08, 16'h0200);
        send(2'h0, 1'b0, 16'h0108);
        `CHK({fast_alert[0], sustained_alert[0]}, 2'h2)
        mrl_host_inst.wr(8'h0a, 16'h0200);
        send(2'h1, 1'b0, 16'h0108);
        `CHK({fast_alert[1], sustained_alert[1]}, 2'h2)
        $display("alerts done");
        mode_sel <= 3'h0;
        send(2'h2, 1'b1, 16'h7ff8);
        expect_reg(8'h06, 16'hfff8);
        mode_sel <= 3'h6;
        send(2'h2, 1'b0, 16'h1000);
        expect_reg(8'h05, 16'h0100);
        avg_sel <= 3'h2;
        repeat (15) send(2'h2, 1'b1, 16'h0080);
        expect_reg(8'h06, 16'hfff8);
        send(2'h2, 1'b1, 16'h0080);
        expect_reg(8'h06, 16'h0080);
        $display("modes done");
        complete_run();
    end
endmodule // mrl_regs_test
